//--- msc_map.svh
// Constants for the mute sequence controller: register offsets, fields, resets, timing.
// Assumes a 40 MHz system clock and byte addresses on an 8-bit register port.
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// Register offsets.
`define MSC_REG_CTRL 8'h00
`define MSC_REG_WINDOW 8'h04
`define MSC_REG_LIMIT 8'h08
`define MSC_REG_STATUS 8'h0c

// Control register fields.
`define MSC_CTRL_PAIR1 0
`define MSC_CTRL_PAIR2 1
`define MSC_CTRL_PARTIAL 2
`define MSC_CTRL_PSEL 3
`define MSC_CTRL_LAMP1 4
`define MSC_CTRL_LAMP2 5
`define MSC_CTRL_OVR 6
`define MSC_CTRL_W 7
`define MSC_CTRL_RST 7'h00

// Window register holds seconds minus one; limit register holds minutes.
`define MSC_WIN_W 4
`define MSC_WIN_RST 4'h3
`define MSC_LIMIT_W 11
`define MSC_LIMIT_RST 11'h00a
`define MSC_LIMIT_MIN 11'h00a
`define MSC_LIMIT_MAX 11'h438

// Status register fields.
`define MSC_ST_MUTED 0
`define MSC_ST_FAULT 1
`define MSC_ST_OVR 2
`define MSC_ST_STATE 4
`define MSC_ST_SENS 8

// Timing.
`define MSC_CLK_PERIOD_NS 25
`define MSC_HALF_SEC_NS 500000000
`define MSC_HALF_SEC_CYC (`MSC_HALF_SEC_NS / `MSC_CLK_PERIOD_NS)
`define MSC_HALF_PER_MIN 120

`endif

//--- msc_pkg.sv
// Types shared by the mute sequence controller files.
// Assumes nothing beyond the constants header.
package msc_pkg;
	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_wait2 = 4'h2,
		st_muted = 4'h4,
		st_block = 4'h8
	} msc_state_t;
	typedef logic [1:0] msc_zone_t;
endpackage

//--- msc_tick_if.sv
// Time base ticks passed from the timebase to the mute controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface msc_tick_if;
	logic restart;
	logic half_tick;
	logic sec_tick;
	logic min_tick;
	modport timer (input restart, output half_tick, sec_tick, min_tick);
	modport user (output restart, input half_tick, sec_tick, min_tick);
endinterface

//--- msc_timebase.sv
// Restartable half-second, second and minute tick generator.
// Assumes one clock; HALF_SEC_CYC is at least 2.
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_timebase #(
	parameter int HALF_SEC_CYC = `MSC_HALF_SEC_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Ticks.
	msc_tick_if.timer tick
);
	localparam int HW = $clog2(HALF_SEC_CYC);
	logic [HW-1:0] half_cnt;
	logic half_in_sec;
	logic [6:0] half_in_min;
	logic wrap;

	assign wrap = (half_cnt == HW'(HALF_SEC_CYC - 1));

	////////////////////////////////////////////////////////////////////////////
	// A restart realigns every tick so a timed interval starts at a full period.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			half_cnt <= '0;
		end else if (tick.restart || wrap) begin
			half_cnt <= '0;
		end else begin
			half_cnt <= half_cnt + HW'(1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			half_in_sec <= 1'b0;
			half_in_min <= 7'h00;
		end else if (tick.restart) begin
			half_in_sec <= 1'b0;
			half_in_min <= 7'h00;
		end else if (wrap) begin
			half_in_sec <= ~half_in_sec;
			half_in_min <= (half_in_min == 7'(`MSC_HALF_PER_MIN - 1)) ? 7'h00 : half_in_min + 7'h01;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick.half_tick <= 1'b0;
			tick.sec_tick <= 1'b0;
			tick.min_tick <= 1'b0;
		end else begin
			tick.half_tick <= wrap && !tick.restart;
			tick.sec_tick <= wrap && half_in_sec && !tick.restart;
			tick.min_tick <= wrap && !tick.restart && (half_in_min == 7'(`MSC_HALF_PER_MIN - 1));
		end
	end
endmodule

//--- msc_mute_ctrl.sv
// Mute sequence controller: two-sensor simultaneity check, permit gating, mute timer.
// Assumes pins are asynchronous to clk_i and software uses the plain register port.
// Operation
// - Only zones of safety output pairs 1 and 2 may be muted; pair 3 never.
// - Configuration selects total or partial zone muting.
// - Both sensors must activate within a 1 to 16 second window, default 4.
// - Either sensor may activate first.
// - Activations in the same instant never start a mute.
// - Second activation after the window has elapsed starts no mute.
// - Zone set is frozen while muted; a change attempt raises the fault.
// - No mute at power up; only a fresh sensor sequence starts one.
// - The permit function is assigned to permit input 1 or 2.
// - A mute may start only while the assigned permit input is high.
// - A low or open permit input blocks muting.
// - Enabled mute lamps toggle on and off while muted.
// - Maximum mute time is 10 to 1080 minutes in one-minute steps.
// - The mute timer starts when the second sensor meets the window.
// - Timer expiry ends the mute whatever the sensors show.
// - A limit of zero minutes disables the timer.
// - After a timed-out mute an override stays permitted if configured.
// - The mute time limit defaults to 10 minutes.
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_mute_ctrl #(
	parameter int HALF_SEC_CYC = `MSC_HALF_SEC_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Sensor, permit and zone set pins.
	input wire logic mute1_i,
	input wire logic mute2_i,
	input wire logic mute_permit_input1_i,
	input wire logic mute_permit_input2_i,
	input wire msc_pkg::msc_zone_t zone_sel1_i,
	input wire msc_pkg::msc_zone_t zone_sel2_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Mute results.
	output logic mute_pair1_o,
	output logic mute_pair2_o,
	output logic mute_partial_o,
	output msc_pkg::msc_zone_t zone_set_pair1_o,
	output msc_pkg::msc_zone_t zone_set_pair2_o,
	output logic lamp1_o,
	output logic lamp2_o,
	output logic mute_zone_change_fault_o,
	output logic override_permit_o
);
	import msc_pkg::*;

	msc_tick_if tick ();
	msc_state_t state;
	msc_state_t next_state;
	logic [7:0] pin_raw;
	logic [7:0] pin_s1;
	logic [7:0] pin_s2;
	logic m1;
	logic m2;
	logic permit_act;
	msc_zone_t zs1;
	msc_zone_t zs2;
	logic [`MSC_CTRL_W-1:0] ctrl;
	logic [`MSC_WIN_W-1:0] win;
	logic [`MSC_LIMIT_W-1:0] limit;
	logic [4:0] win_cnt;
	logic [4:0] win_secs;
	logic [`MSC_LIMIT_W-1:0] min_cnt;
	logic win_over;
	logic expire;
	logic blink;
	logic any_pair;

	msc_timebase #(
		.HALF_SEC_CYC(HALF_SEC_CYC)
	) u_timebase (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick(tick.timer)
	);

	////////////////////////////////////////////////////////////////////////////
	// Every pin passes two flip-flops; the first stage feeds only the second.
	assign pin_raw = {zone_sel2_i, zone_sel1_i, mute_permit_input2_i, mute_permit_input1_i,
		mute2_i, mute1_i};
	generate
		for (genvar g = 0; g < 8; g++) begin : g_sync
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					pin_s1[g] <= 1'b0;
					pin_s2[g] <= 1'b0;
				end else begin
					pin_s1[g] <= pin_raw[g];
					pin_s2[g] <= pin_s1[g];
				end
			end
		end
	endgenerate

	assign m1 = pin_s2[0];
	assign m2 = pin_s2[1];
	assign zs1 = pin_s2[5:4];
	assign zs2 = pin_s2[7:6];
	// An open pin reads low, so it never permits.
	assign permit_act = ctrl[`MSC_CTRL_PSEL] ? pin_s2[3] : pin_s2[2];
	assign any_pair = ctrl[`MSC_CTRL_PAIR1] || ctrl[`MSC_CTRL_PAIR2];

	////////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= `MSC_CTRL_RST;
			win <= `MSC_WIN_RST;
			limit <= `MSC_LIMIT_RST;
		end else if (wr_i) begin
			case (addr_i)
				`MSC_REG_CTRL: begin
					ctrl <= wdata_i[`MSC_CTRL_W-1:0];
				end
				`MSC_REG_WINDOW: begin
					win <= wdata_i[`MSC_WIN_W-1:0];
				end
				`MSC_REG_LIMIT: begin
					if (wdata_i[31:`MSC_LIMIT_W] == '0 && (wdata_i[`MSC_LIMIT_W-1:0] == '0 ||
						(wdata_i[`MSC_LIMIT_W-1:0] >= `MSC_LIMIT_MIN &&
						wdata_i[`MSC_LIMIT_W-1:0] <= `MSC_LIMIT_MAX))) begin
						limit <= wdata_i[`MSC_LIMIT_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				`MSC_REG_CTRL: rdata_o <= {25'h0, ctrl};
				`MSC_REG_WINDOW: rdata_o <= {28'h0, win};
				`MSC_REG_LIMIT: rdata_o <= {21'h0, limit};
				`MSC_REG_STATUS: rdata_o <= {22'h0, m2, m1, state, 1'b0, override_permit_o,
					mute_zone_change_fault_o, state == st_muted};
				default: rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence timing.
	assign win_secs = 5'(win) + 5'h01;
	assign win_over = (win_cnt >= win_secs);
	assign expire = (state == st_muted) && (limit != '0) && (min_cnt >= limit);

	// Restart realigns the timebase exactly on the edge that opens an interval.
	// Timer starts at second activation.
	assign tick.restart = ((state == st_idle) && (next_state == st_wait2)) ||
		((state != st_muted) && (next_state == st_muted));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			win_cnt <= 5'h00;
		end else if (state != st_wait2 || tick.restart) begin
			win_cnt <= 5'h00;
		end else if (tick.sec_tick && !win_over) begin
			win_cnt <= win_cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			min_cnt <= '0;
		end else if (state != st_muted) begin
			min_cnt <= '0;
		end else if (tick.min_tick && min_cnt != '1) begin
			min_cnt <= min_cnt + `MSC_LIMIT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence state machine.
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (m1 && m2) begin
					next_state = st_block;
				end else if (m1 || m2) begin
					next_state = st_wait2;
				end
			end
			st_wait2: begin
				if (!m1 && !m2) begin
					next_state = st_idle;
				end else if (m1 && m2) begin
					next_state = (!win_over && permit_act && any_pair) ? st_muted : st_block;
				end else if (win_over) begin
					next_state = st_block;
				end
			end
			st_muted: begin
				if (!m1 || !m2 || expire || !permit_act) begin
					next_state = st_block;
				end
			end
			st_block: begin
				if (!m1 && !m2) begin
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_block;
			end
		endcase
	end

	// Reset lands in the blocked state, so sensors already active never mute.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= st_block;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mute outputs.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mute_pair1_o <= 1'b0;
			mute_pair2_o <= 1'b0;
			mute_partial_o <= 1'b0;
		end else begin
			mute_pair1_o <= (next_state == st_muted) && ctrl[`MSC_CTRL_PAIR1];
			mute_pair2_o <= (next_state == st_muted) && ctrl[`MSC_CTRL_PAIR2];
			mute_partial_o <= (next_state == st_muted) && any_pair && ctrl[`MSC_CTRL_PARTIAL];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			zone_set_pair1_o <= 2'h0;
			zone_set_pair2_o <= 2'h0;
		end else begin
			if (!mute_pair1_o) begin
				zone_set_pair1_o <= zs1;
			end
			if (!mute_pair2_o) begin
				zone_set_pair2_o <= zs2;
			end
		end
	end

	// Fault on change attempt; a new attempt wins over a software clear.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mute_zone_change_fault_o <= 1'b0;
		end else if ((mute_pair1_o && zs1 != zone_set_pair1_o) ||
			(mute_pair2_o && zs2 != zone_set_pair2_o)) begin
			mute_zone_change_fault_o <= 1'b1;
		end else if (wr_i && addr_i == `MSC_REG_STATUS && wdata_i[`MSC_ST_FAULT]) begin
			mute_zone_change_fault_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			override_permit_o <= 1'b0;
		end else if (expire && ctrl[`MSC_CTRL_OVR]) begin
			override_permit_o <= 1'b1;
		end else if (state == st_idle) begin
			override_permit_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			blink <= 1'b0;
			lamp1_o <= 1'b0;
			lamp2_o <= 1'b0;
		end else begin
			blink <= (state != st_muted) ? 1'b1 : (tick.half_tick ? ~blink : blink);
			lamp1_o <= (state == st_muted) && ctrl[`MSC_CTRL_LAMP1] && blink;
			lamp2_o <= (state == st_muted) && ctrl[`MSC_CTRL_LAMP2] && blink;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_mute_entry;
		(state == st_wait2) ##1 (state == st_muted);
	endsequence

	property p_pair_enable;
		mute_pair1_o |-> $past(ctrl[`MSC_CTRL_PAIR1]) && (state == st_muted);
	endproperty
	a_pair_enable: assert property (p_pair_enable) else $error("pair 1 muted without enable");

	property p_partial;
		mute_partial_o |-> (mute_pair1_o || mute_pair2_o || !$past(any_pair));
	endproperty
	a_partial: assert property (p_partial) else $error("partial mute with no pair muted");

	property p_same_instant;
		(state == st_idle) && m1 && m2 |=> (state == st_block) && !mute_pair1_o && !mute_pair2_o;
	endproperty
	a_same_instant: assert property (p_same_instant) else $error("simultaneous start not blocked");

	property p_late;
		(state == st_wait2) && win_over |=> (state != st_muted);
	endproperty
	a_late: assert property (p_late) else $error("mute started after window");

	property p_permit;
		s_mute_entry |-> $past(permit_act);
	endproperty
	a_permit: assert property (p_permit) else $error("mute started without permit");

	property p_zone_hold;
		mute_pair1_o ##1 mute_pair1_o |-> $stable(zone_set_pair1_o);
	endproperty
	a_zone_hold: assert property (p_zone_hold) else $error("zone set moved during mute");

	property p_zone_fault;
		mute_pair2_o && (zs2 != zone_set_pair2_o) |=> mute_zone_change_fault_o;
	endproperty
	a_zone_fault: assert property (p_zone_fault) else $error("zone change fault missed");

	property p_timer_start;
		s_mute_entry |-> (min_cnt == '0) && !expire;
	endproperty
	a_timer_start: assert property (p_timer_start) else $error("mute timer not fresh");

	property p_expire;
		expire |=> (state == st_block) ##1 !mute_pair1_o && !mute_pair2_o;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry did not end mute");

	property p_unlimited;
		(limit == '0) |-> !expire;
	endproperty
	a_unlimited: assert property (p_unlimited) else $error("timer ran with zero limit");

	property p_release;
		(state == st_muted) && !(m1 && m2) |=> (state == st_block) ##1 !mute_pair1_o;
	endproperty
	a_release: assert property (p_release) else $error("sensor release kept mute");

	property p_rearm;
		(state == st_block) && (m1 || m2) |=> (state == st_block);
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearmed with a sensor active");

	property p_lamp;
		lamp1_o |-> $past(state == st_muted);
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp lit outside mute");
endmodule

//--- msc_partner.sv
// Model of the far side: two mute sensors and the machine control logic.
// Assumes the testbench commands actuation, power, permit window and zone requests.
`timescale 1ns/1ps
module msc_partner (
	// Commands from the testbench.
	input wire logic act1_i,
	input wire logic act2_i,
	input wire logic powered_i,
	input wire logic permit_open_i,
	input wire logic permit_sel_i,
	input wire msc_pkg::msc_zone_t zone_req1_i,
	input wire msc_pkg::msc_zone_t zone_req2_i,
	// Pins towards the controller.
	output logic mute1_o,
	output logic mute2_o,
	output logic permit1_o,
	output logic permit2_o,
	output msc_pkg::msc_zone_t zone_sel1_o,
	output msc_pkg::msc_zone_t zone_sel2_o
);
	import msc_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// Sensors drive active only while actuated and powered.
	assign mute1_o = act1_i & powered_i;
	assign mute2_o = act2_i & powered_i;
	// Machine opens permit window.
	// The unused permit pin is driven low, never left floating.
	assign permit1_o = permit_open_i & ~permit_sel_i;
	assign permit2_o = permit_open_i & permit_sel_i;
	assign zone_sel1_o = zone_req1_i;
	assign zone_sel2_o = zone_req2_i;
endmodule

//--- test_mute_sequence_controller.sv
// Self-checking testbench for the mute sequence controller.
// Assumes the partner model on the pins and the plain register port.
`timescale 1ns/1ps
`include "msc_map.svh"
module test_mute_sequence_controller;
	import msc_pkg::*;
	// A short half second keeps the minute timer within a short run.
	localparam int HSC = 8;
	logic clk_i, rst_i, wr_i, rd_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic act1, act2, pwr, permit_open, permit_sel;
	logic mute1, mute2, permit1, permit2;
	msc_zone_t zreq1, zreq2, zsel1, zsel2, zset1, zset2;
	logic mp1, mp2, mpart, lamp1, lamp2, fault, ovr, l0;
	int error_cnt, comparisons, cycles;
	logic [31:0] lim_w[4] = '{32'h9, 32'h439, 32'h438, 32'h0};
	logic [31:0] lim_e[4] = '{32'ha, 32'ha, 32'h438, 32'h0};
	////////////////////////////////////////////////////////////////////////////
	msc_partner far (.act1_i(act1), .act2_i(act2), .powered_i(pwr),
		.permit_open_i(permit_open), .permit_sel_i(permit_sel), .zone_req1_i(zreq1),
		.zone_req2_i(zreq2), .mute1_o(mute1), .mute2_o(mute2), .permit1_o(permit1),
		.permit2_o(permit2), .zone_sel1_o(zsel1), .zone_sel2_o(zsel2));
	msc_mute_ctrl #(.HALF_SEC_CYC(HSC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.mute1_i(mute1), .mute2_i(mute2), .mute_permit_input1_i(permit1),
		.mute_permit_input2_i(permit2), .zone_sel1_i(zsel1), .zone_sel2_i(zsel2),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.mute_pair1_o(mp1), .mute_pair2_o(mp2), .mute_partial_o(mpart),
		.zone_set_pair1_o(zset1), .zone_set_pair2_o(zset2), .lamp1_o(lamp1),
		.lamp2_o(lamp2), .mute_zone_change_fault_o(fault), .override_permit_o(ovr));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// The run needs about 20000 cycles.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(name, rdata_o, exp);
	endtask
	// Gap zero actuates both sensors at the same edge.
	task automatic seq(input logic first1, input int gap);
		@(posedge clk_i);
		if (first1) act1 <= 1'b1;
		else act2 <= 1'b1;
		repeat (gap) @(posedge clk_i);
		if (first1) act2 <= 1'b1;
		else act1 <= 1'b1;
		cyc(6);
	endtask
	task automatic idle;
		@(posedge clk_i);
		act1 <= 1'b0;
		act2 <= 1'b0;
		cyc(6);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		{act1, act2, permit_sel} = 3'h0;
		{pwr, permit_open} = 2'h3;
		zreq1 = 2'h0;
		zreq2 = 2'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(4);
		chk("mute_pair1", mp1, 32'h0);
		rchk("ctrl", `MSC_REG_CTRL, 32'h0);
		rchk("window", `MSC_REG_WINDOW, 32'h3);
		rchk("limit", `MSC_REG_LIMIT, 32'ha);
		rchk("status", `MSC_REG_STATUS, 32'h10);
		rchk("unmapped", 8'h10, 32'h0);
		foreach (lim_w[i]) begin
			wr(`MSC_REG_LIMIT, lim_w[i]);
			rchk("limit", `MSC_REG_LIMIT, lim_e[i]);
		end
		wr(`MSC_REG_CTRL, 32'h15);
		wr(`MSC_REG_WINDOW, 32'h0);
		seq(1'b1, 4);
		chk("mute_pair1", mp1, 32'h1);
		chk("mute_pair2", mp2, 32'h0);
		chk("partial", mpart, 32'h1);
		l0 = lamp1;
		cyc(HSC);
		chk("lamp1", lamp1, {31'h0, ~l0});
		chk("lamp2", lamp2, 32'h0);
		cyc(9800);
		chk("mute_pair1", mp1, 32'h1);
		zreq1 <= 2'h1;
		cyc(6);
		chk("fault", fault, 32'h1);
		chk("zone_set1", zset1, 32'h0);
		chk("zone_set2", zset2, 32'h0);
		@(posedge clk_i);
		act1 <= 1'b0;
		cyc(4);
		chk("mute_pair1", mp1, 32'h0);
		@(posedge clk_i);
		act1 <= 1'b1;
		cyc(6);
		chk("mute_pair1", mp1, 32'h0);
		idle();
		wr(`MSC_REG_STATUS, 32'h2);
		cyc(2);
		chk("fault", fault, 32'h0);
		chk("zone_set1", zset1, 32'h1);
		wr(`MSC_REG_CTRL, 32'h02);
		seq(1'b0, 4);
		chk("mute_pair2", mp2, 32'h1);
		chk("mute_pair1", mp1, 32'h0);
		chk("partial", mpart, 32'h0);
		idle();
		seq(1'b1, 0);
		chk("mute_pair2", mp2, 32'h0);
		idle();
		seq(1'b1, 40);
		chk("mute_pair2", mp2, 32'h0);
		idle();
		permit_open <= 1'b0;
		seq(1'b1, 4);
		chk("mute_pair2", mp2, 32'h0);
		idle();
		permit_open <= 1'b1;
		wr(`MSC_REG_CTRL, 32'h0a);
		seq(1'b1, 4);
		chk("mute_pair2", mp2, 32'h0);
		idle();
		permit_sel <= 1'b1;
		seq(1'b1, 4);
		chk("mute_pair2", mp2, 32'h1);
		permit_open <= 1'b0;
		cyc(6);
		chk("mute_pair2", mp2, 32'h0);
		idle();
		permit_sel <= 1'b0;
		permit_open <= 1'b1;
		wr(`MSC_REG_CTRL, 32'h41);
		wr(`MSC_REG_LIMIT, 32'ha);
		seq(1'b1, 4);
		cyc(9000);
		chk("mute_pair1", mp1, 32'h1);
		cyc(800);
		chk("mute_pair1", mp1, 32'h0);
		chk("override", ovr, 32'h1);
		idle();
		chk("override", ovr, 32'h0);
		final_report();
	end
endmodule
